// ### src/mfs_pkg.sv
// Package for the motor fault and status register block.
// Holds the register address, field positions, reset value and stall counts.
// Assumes a single 20 MHz clock domain shared by all users of this package.
package mfs_pkg;

  // ********************************
  // Register port geometry
  // ********************************
  localparam int ADDR_W = 3;
  localparam int DATA_W = 12;
  localparam logic [ADDR_W-1:0] FAULT_STATUS_ADDR = 3'h7;
  localparam logic [DATA_W-1:0] FAULT_STATUS_RESET = 12'h000;

  // ********************************
  // Field positions inside fault_status
  // ********************************
  localparam int OVERTEMP_BIT = 0;
  localparam int CHAN_A_OCP_BIT = 1;
  localparam int CHAN_B_OCP_BIT = 2;
  localparam int CHAN_A_PDF_BIT = 3;
  localparam int CHAN_B_PDF_BIT = 4;
  localparam int UNDERVOLT_BIT = 5;
  localparam int LIVE_STALL_BIT = 6;
  localparam int LATCHED_STALL_BIT = 7;
  localparam int FLAG_COUNT = 8;

  // ********************************
  // Stall step counting
  // ********************************
  localparam int STALL_CNT_W = 4;
  localparam logic [1:0] STALL_SEL_ONE = 2'h0;
  localparam logic [1:0] STALL_SEL_TWO = 2'h1;
  localparam logic [1:0] STALL_SEL_FOUR = 2'h2;
  localparam logic [STALL_CNT_W-1:0] STALL_STEPS_ONE = 4'h1;
  localparam logic [STALL_CNT_W-1:0] STALL_STEPS_TWO = 4'h2;
  localparam logic [STALL_CNT_W-1:0] STALL_STEPS_FOUR = 4'h4;
  localparam logic [STALL_CNT_W-1:0] STALL_STEPS_EIGHT = 4'h8;
  localparam logic [STALL_CNT_W-1:0] STALL_CNT_RESET = 4'h0;

endpackage

// ### src/mfs_stall_counter.sv
// Stall declaration counter: counts consecutive steps with weak back-EMF.
// Assumes the step strobe and the below-threshold level are synchronous.
`timescale 1ns/1ps

module mfs_stall_counter (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_step,
  input wire logic i_bemf_below,
  input wire logic [1:0] i_stall_step_count,
  output logic o_live_stall
);
  import mfs_pkg::*;

  // ********************************
  // Step count lookup
  // ********************************
  // Number of weak steps needed before a stall is declared
  function automatic logic [STALL_CNT_W-1:0] steps_needed(
    input logic [1:0] sel
  );
    logic [STALL_CNT_W-1:0] n;
    n = STALL_STEPS_EIGHT;
    if (sel == STALL_SEL_ONE) begin
      n = STALL_STEPS_ONE;
    end else if (sel == STALL_SEL_TWO) begin
      n = STALL_STEPS_TWO;
    end else if (sel == STALL_SEL_FOUR) begin
      n = STALL_STEPS_FOUR;
    end
    return n;
  endfunction

  logic [STALL_CNT_W-1:0] cnt_r;
  logic [STALL_CNT_W-1:0] cnt_nxt;
  logic live_r;
  logic live_nxt;
  logic [STALL_CNT_W-1:0] target;

  // ********************************
  // Counter next state
  // ********************************
  // Saturates at the target so a long stall cannot wrap back to zero
  always_comb begin
    target = steps_needed(i_stall_step_count);
    cnt_nxt = cnt_r;
    live_nxt = live_r;
    if (i_step) begin
      if (i_bemf_below) begin
        if (cnt_r < target) begin
          cnt_nxt = cnt_r + STALL_STEPS_ONE;
        end
        live_nxt = (cnt_nxt >= target); // R11
      end else begin
        cnt_nxt = STALL_CNT_RESET; // R11
        live_nxt = 1'h0; // R9
      end
    end
  end

  // Registers only
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= STALL_CNT_RESET;
      live_r <= 1'h0;
    end else begin
      cnt_r <= cnt_nxt;
      live_r <= live_nxt;
    end
  end

  assign o_live_stall = live_r;

endmodule

// ### src/mfs_fault_status.sv
// Fault and status register of a stepper pre-driver controller.
// Assumes the serial port decoder presents word accesses on i_reg_* pins
// and that fault detectors give synchronous levels or strobes.
//
// Contract
// R1 - Bit 0 reads 1 during thermal shutdown, 0 otherwise.
// R2 - Bit 0 self-clears when temperature is safe; writes are ignored.
// R3 - Bit 1 latches channel A overcurrent shutdown until host clears.
// R4 - Bit 2 latches channel B overcurrent shutdown until host clears.
// R5 - Bit 3 latches channel A predriver fault until cleared.
// R6 - Bit 4 latches channel B predriver fault until cleared.
// R7 - Host writes zero to latched flag; flag clears, function resumes.
// R8 - Bit 5 reads 1 in undervoltage lockout, clears automatically.
// R9 - Bit 6 shows live stall detection without latching.
// R10 - Bit 7 latches stall until host writes zero.
// R11 - Stall declared after 1, 2, 4 or 8 weak-EMF steps per setting.
// R12 - Bits 11..8 read zero; writing one leaves latched flags unchanged.
// R13 - All flags reset to zero.
`timescale 1ns/1ps

module mfs_fault_status (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [mfs_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [mfs_pkg::DATA_W-1:0] i_reg_wdata,
  input wire logic i_overtemp,
  input wire logic i_chan_a_overcurrent,
  input wire logic i_chan_b_overcurrent,
  input wire logic i_chan_a_predriver_fault,
  input wire logic i_chan_b_predriver_fault,
  input wire logic i_motor_supply_low,
  input wire logic i_step,
  input wire logic i_bemf_below,
  input wire logic [1:0] i_stall_step_count,
  output logic [mfs_pkg::DATA_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic [mfs_pkg::DATA_W-1:0] o_fault_status,
  output logic o_chan_a_enable,
  output logic o_chan_b_enable,
  output logic o_stall_out_n,
  output logic o_fault_n
);
  import mfs_pkg::*;

  // ********************************
  // Declarations
  // ********************************
  logic overtemp_shutdown_flag_r;
  logic chan_a_overcurrent_flag_r;
  logic chan_b_overcurrent_flag_r;
  logic chan_a_predriver_fault_flag_r;
  logic chan_b_predriver_fault_flag_r;
  logic supply_undervoltage_flag_r;
  logic live_stall_flag_r;
  logic latched_stall_flag_r;
  logic overtemp_shutdown_flag_nxt;
  logic chan_a_overcurrent_flag_nxt;
  logic chan_b_overcurrent_flag_nxt;
  logic chan_a_predriver_fault_flag_nxt;
  logic chan_b_predriver_fault_flag_nxt;
  logic supply_undervoltage_flag_nxt;
  logic live_stall_flag_nxt;
  logic latched_stall_flag_nxt;
  logic [DATA_W-1:0] status_image;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic chan_a_en_r;
  logic chan_a_en_nxt;
  logic chan_b_en_r;
  logic chan_b_en_nxt;
  logic stall_n_r;
  logic stall_n_nxt;
  logic fault_n_r;
  logic fault_n_nxt;
  logic status_wr;
  logic stall_live;

  // ********************************
  // Write decode
  // ********************************
  // Only a write to the status address may clear latched flags
  function automatic logic clear_req(
    input logic wr,
    input logic [DATA_W-1:0] wdata,
    input int pos
  );
    return wr && !wdata[pos]; // R7 R12
  endfunction

  always_comb begin
    status_wr = 1'h0;
    if (i_reg_wr && (i_reg_addr == FAULT_STATUS_ADDR)) begin
      status_wr = 1'h1;
    end
  end

  // ********************************
  // Stall detection
  // ********************************
  mfs_stall_counter u_stall (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_step(i_step),
    .i_bemf_below(i_bemf_below),
    .i_stall_step_count(i_stall_step_count),
    .o_live_stall(stall_live)
  );

  // ********************************
  // Flag next state
  // ********************************
  // A fault that arrives in the clearing cycle wins, so no event is lost
  always_comb begin
    overtemp_shutdown_flag_nxt = i_overtemp; // R1 R2
    supply_undervoltage_flag_nxt = i_motor_supply_low; // R8
    live_stall_flag_nxt = stall_live; // R9
    chan_a_overcurrent_flag_nxt = i_chan_a_overcurrent // R3
      | (chan_a_overcurrent_flag_r
         & !clear_req(status_wr, i_reg_wdata, CHAN_A_OCP_BIT));
    chan_b_overcurrent_flag_nxt = i_chan_b_overcurrent // R4
      | (chan_b_overcurrent_flag_r
         & !clear_req(status_wr, i_reg_wdata, CHAN_B_OCP_BIT));
    chan_a_predriver_fault_flag_nxt = i_chan_a_predriver_fault // R5
      | (chan_a_predriver_fault_flag_r
         & !clear_req(status_wr, i_reg_wdata, CHAN_A_PDF_BIT));
    chan_b_predriver_fault_flag_nxt = i_chan_b_predriver_fault // R6
      | (chan_b_predriver_fault_flag_r
         & !clear_req(status_wr, i_reg_wdata, CHAN_B_PDF_BIT));
    latched_stall_flag_nxt = stall_live // R10
      | (latched_stall_flag_r
         & !clear_req(status_wr, i_reg_wdata, LATCHED_STALL_BIT));
  end

  // Flag registers
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      overtemp_shutdown_flag_r <= 1'h0; // R13
      chan_a_overcurrent_flag_r <= 1'h0;
      chan_b_overcurrent_flag_r <= 1'h0;
      chan_a_predriver_fault_flag_r <= 1'h0;
      chan_b_predriver_fault_flag_r <= 1'h0;
      supply_undervoltage_flag_r <= 1'h0;
      live_stall_flag_r <= 1'h0;
      latched_stall_flag_r <= 1'h0;
    end else begin
      overtemp_shutdown_flag_r <= overtemp_shutdown_flag_nxt;
      chan_a_overcurrent_flag_r <= chan_a_overcurrent_flag_nxt;
      chan_b_overcurrent_flag_r <= chan_b_overcurrent_flag_nxt;
      chan_a_predriver_fault_flag_r <= chan_a_predriver_fault_flag_nxt;
      chan_b_predriver_fault_flag_r <= chan_b_predriver_fault_flag_nxt;
      supply_undervoltage_flag_r <= supply_undervoltage_flag_nxt;
      live_stall_flag_r <= live_stall_flag_nxt;
      latched_stall_flag_r <= latched_stall_flag_nxt;
    end
  end

  // ********************************
  // Register image and outputs
  // ********************************
  // Reserved upper bits are tied low in the image
  always_comb begin
    status_image = FAULT_STATUS_RESET; // R12
    status_image[OVERTEMP_BIT] = overtemp_shutdown_flag_r;
    status_image[CHAN_A_OCP_BIT] = chan_a_overcurrent_flag_r;
    status_image[CHAN_B_OCP_BIT] = chan_b_overcurrent_flag_r;
    status_image[CHAN_A_PDF_BIT] = chan_a_predriver_fault_flag_r;
    status_image[CHAN_B_PDF_BIT] = chan_b_predriver_fault_flag_r;
    status_image[UNDERVOLT_BIT] = supply_undervoltage_flag_r;
    status_image[LIVE_STALL_BIT] = live_stall_flag_r;
    status_image[LATCHED_STALL_BIT] = latched_stall_flag_r;
  end

  // Enable, stall and fault outputs are computed from next flag values so each is a plain flop
  // yet tracks the flag in the same cycle; read data is taken from the current image
  always_comb begin
    rvalid_nxt = i_reg_rd;
    rdata_nxt = FAULT_STATUS_RESET;
    if (i_reg_rd && (i_reg_addr == FAULT_STATUS_ADDR)) begin
      rdata_nxt = status_image;
    end
    // Bridge shutdown lifts as soon as the latched faults are cleared
    chan_a_en_nxt = !(chan_a_overcurrent_flag_nxt
      | chan_a_predriver_fault_flag_nxt | overtemp_shutdown_flag_nxt
      | supply_undervoltage_flag_nxt); // R7
    chan_b_en_nxt = !(chan_b_overcurrent_flag_nxt
      | chan_b_predriver_fault_flag_nxt | overtemp_shutdown_flag_nxt
      | supply_undervoltage_flag_nxt); // R7
    stall_n_nxt = !latched_stall_flag_nxt;
    fault_n_nxt = !(overtemp_shutdown_flag_nxt
      | chan_a_overcurrent_flag_nxt | chan_b_overcurrent_flag_nxt
      | chan_a_predriver_fault_flag_nxt | chan_b_predriver_fault_flag_nxt
      | supply_undervoltage_flag_nxt);
  end

  // Output registers
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_r <= FAULT_STATUS_RESET;
      rvalid_r <= 1'h0;
      chan_a_en_r <= 1'h1;
      chan_b_en_r <= 1'h1;
      stall_n_r <= 1'h1;
      fault_n_r <= 1'h1;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      chan_a_en_r <= chan_a_en_nxt;
      chan_b_en_r <= chan_b_en_nxt;
      stall_n_r <= stall_n_nxt;
      fault_n_r <= fault_n_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_reg_rvalid = rvalid_r;
  assign o_fault_status = status_image;
  assign o_chan_a_enable = chan_a_en_r;
  assign o_chan_b_enable = chan_b_en_r;
  assign o_stall_out_n = stall_n_r;
  assign o_fault_n = fault_n_r;

endmodule

// ### bench/mfs_chk.sv
// Checker of the fault and status register, bound to its top module.
// Assumes one clock domain and inputs that change only off the rising edge.
`timescale 1ns/1ps
module mfs_chk (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [mfs_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [mfs_pkg::DATA_W-1:0] i_reg_wdata,
  input wire logic i_overtemp,
  input wire logic i_chan_a_overcurrent,
  input wire logic i_chan_b_overcurrent,
  input wire logic i_chan_a_predriver_fault,
  input wire logic i_motor_supply_low,
  input wire logic [mfs_pkg::DATA_W-1:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic [mfs_pkg::DATA_W-1:0] o_fault_status,
  input wire logic o_chan_a_enable,
  input wire logic o_stall_out_n,
  input wire logic o_fault_n
);
  import mfs_pkg::*;
  logic wr7;
  // ****
  // Properties
  // ****
  // Write aimed at the status word
  assign wr7 = i_reg_wr && i_reg_addr == FAULT_STATUS_ADDR;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  sequence rd_req_s;
    i_reg_rd && i_reg_addr == FAULT_STATUS_ADDR;
  endsequence
  // Read must return the image from before its own edge
  sequence rd_ans_s;
    o_reg_rvalid && o_reg_rdata == $past(o_fault_status);
  endsequence
  ot_follow_a: assert property ($past(i_resetn) |->
    o_fault_status[OVERTEMP_BIT] == $past(i_overtemp))
    else $error("overtemp flag does not follow its input");
  uv_follow_a: assert property ($past(i_resetn) |->
    o_fault_status[UNDERVOLT_BIT] == $past(i_motor_supply_low))
    else $error("undervoltage flag does not follow its input");
  ocpa_set_a: assert property (i_chan_a_overcurrent |=>
    o_fault_status[CHAN_A_OCP_BIT] && !o_chan_a_enable && !o_fault_n)
    else $error("channel A overcurrent not latched");
  ocpb_set_a: assert property (i_chan_b_overcurrent |=>
    o_fault_status[CHAN_B_OCP_BIT])
    else $error("channel B overcurrent not latched");
  pdfa_set_a: assert property (i_chan_a_predriver_fault |=>
    o_fault_status[CHAN_A_PDF_BIT])
    else $error("channel A predriver fault not latched");
  pdfb_hold_a: assert property (o_fault_status[CHAN_B_PDF_BIT] &&
    !(wr7 && !i_reg_wdata[CHAN_B_PDF_BIT]) |=> o_fault_status[CHAN_B_PDF_BIT])
    else $error("channel B predriver flag lost without clear");
  ocp_clear_a: assert property (wr7 && !i_reg_wdata[CHAN_A_OCP_BIT] &&
    !i_chan_a_overcurrent |=> !o_fault_status[CHAN_A_OCP_BIT])
    else $error("channel A overcurrent flag not cleared");
  stall_latch_a: assert property (o_fault_status[LIVE_STALL_BIT] |->
    o_fault_status[LATCHED_STALL_BIT] && !o_stall_out_n)
    else $error("live stall without latched stall");
  resv_zero_a: assert property (o_fault_status[11:8] == 4'h0 &&
    o_reg_rdata[11:8] == 4'h0)
    else $error("reserved bits not zero");
  rd_answer_a: assert property (rd_req_s |=> rd_ans_s)
    else $error("read answer missing or wrong");
endmodule
bind mfs_fault_status mfs_chk chk_u (.*);

// ### bench/mfs_host.sv
// Host model that issues word accesses on the register port.
// Assumes the bench calls access once a cycle just after the rising edge.
`timescale 1ns/1ps
module mfs_host (
  output logic [mfs_pkg::ADDR_W-1:0] o_reg_addr,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [mfs_pkg::DATA_W-1:0] o_reg_wdata
);
  import mfs_pkg::*;
  // ****
  // Access
  // ****
  // Idle port from time zero
  initial begin
    o_reg_addr = '0;
    o_reg_wr = 1'h0;
    o_reg_rd = 1'h0;
    o_reg_wdata = '0;
  end
  // Request stands until the next edge; idle data toggles so no stale value
  task access(input logic rd, input logic wr, input logic [ADDR_W-1:0] addr,
    input logic [DATA_W-1:0] data);
    o_reg_rd = rd;
    o_reg_wr = wr;
    o_reg_addr = addr;
    o_reg_wdata = wr ? data : ~o_reg_wdata;
  endtask
endmodule

// ### bench/mfs_fault_status_tb.sv
// Random bench of the fault and status register against a cycle model.
// Assumes the host model and checker files are compiled before this one.
`timescale 1ns/1ps
module mfs_fault_status_tb;
  import mfs_pkg::*;
  logic i_clock, i_resetn, i_reg_wr, i_reg_rd, i_overtemp, i_motor_supply_low;
  logic i_chan_a_overcurrent, i_chan_b_overcurrent, i_step, i_bemf_below;
  logic i_chan_a_predriver_fault, i_chan_b_predriver_fault, o_reg_rvalid;
  logic o_chan_a_enable, o_chan_b_enable, o_stall_out_n, o_fault_n, lc, rdp;
  logic [1:0] i_stall_step_count;
  logic [ADDR_W-1:0] i_reg_addr;
  logic [DATA_W-1:0] i_reg_wdata, o_reg_rdata, o_fault_status, m, clr, rdx;
  logic [3:0] r;
  int seed, cnt, checks, miscompares;
  mfs_host host_u (.o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr),
    .o_reg_rd(i_reg_rd), .o_reg_wdata(i_reg_wdata));
  mfs_fault_status dut_u (.i_clock, .i_resetn, .i_reg_addr, .i_reg_wr,
    .i_reg_rd, .i_reg_wdata, .i_overtemp, .i_chan_a_overcurrent,
    .i_chan_b_overcurrent, .i_chan_a_predriver_fault,
    .i_chan_b_predriver_fault, .i_motor_supply_low, .i_step, .i_bemf_below,
    .i_stall_step_count, .o_reg_rdata, .o_reg_rvalid, .o_fault_status,
    .o_chan_a_enable, .o_chan_b_enable, .o_stall_out_n, .o_fault_n);
  // ****
  // Model and comparison
  // ****
  task chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Model state moves on the same edge as the design flops
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      m = '0;
      cnt = 0;
      lc = 0;
      rdp = 0;
      rdx = '0;
    end else begin
      clr = (i_reg_wr && i_reg_addr == FAULT_STATUS_ADDR) ? ~i_reg_wdata : '0;
      rdp = i_reg_rd;
      rdx = (i_reg_rd && i_reg_addr == FAULT_STATUS_ADDR) ? m : '0;
      m[0] = i_overtemp;
      m[1] = i_chan_a_overcurrent | (m[1] & ~clr[1]);
      m[2] = i_chan_b_overcurrent | (m[2] & ~clr[2]);
      m[3] = i_chan_a_predriver_fault | (m[3] & ~clr[3]);
      m[4] = i_chan_b_predriver_fault | (m[4] & ~clr[4]);
      m[5] = i_motor_supply_low;
      m[7] = lc | (m[7] & ~clr[7]);
      m[6] = lc;
      if (i_step && i_bemf_below) begin
        if (cnt < (1 << i_stall_step_count)) cnt++;
        lc = lc | (cnt == (1 << i_stall_step_count));
      end else if (i_step) begin
        cnt = 0;
        lc = 0;
      end
    end
  end
  // Outputs are settled by the falling edge
  always @(negedge i_clock) begin
    if (!i_resetn) chk("status", o_fault_status, FAULT_STATUS_RESET);
    else begin
      chk("status", o_fault_status, m);
      chk("rvalid", 12'(o_reg_rvalid), 12'(rdp));
      chk("rdata", o_reg_rdata, rdx);
      chk("ena", 12'(o_chan_a_enable), 12'(!(m[0] | m[1] | m[3] | m[5])));
      chk("enb", 12'(o_chan_b_enable), 12'(!(m[0] | m[2] | m[4] | m[5])));
      chk("faultn", 12'(o_fault_n), 12'(!(|m[5:0])));
      chk("stall_out_n", 12'(o_stall_out_n), 12'(!m[7]));
    end
  end
  // ****
  // Stimulus
  // ****
  initial begin
    i_clock = 0;
    forever #25 i_clock = ~i_clock;
  end
  // Rare faults so that host clears are seen between events
  task drive();
    i_overtemp = ($random(seed) & 31) == 0;
    i_motor_supply_low = ($random(seed) & 31) == 0;
    i_chan_a_overcurrent = ($random(seed) & 31) == 0;
    i_chan_b_overcurrent = ($random(seed) & 31) == 0;
    i_chan_a_predriver_fault = ($random(seed) & 31) == 0;
    i_chan_b_predriver_fault = ($random(seed) & 31) == 0;
    i_step = ($random(seed) & 3) == 0;
    i_bemf_below = ($random(seed) & 7) != 0;
    r = 4'($random(seed));
    host_u.access(r[0], r[3] & r[2], r[1] ? FAULT_STATUS_ADDR :
      3'($random(seed)), 12'($random(seed)));
  endtask
  // Sweep of all stall settings, each behind its own reset
  initial begin
    seed = 36;
    i_resetn = 0;
    i_stall_step_count = 2'h0;
    drive();
    for (int s = 0; s < 4; s++) begin
      i_stall_step_count = 2'(s);
      repeat (s == 0 ? 16 : 2) @(posedge i_clock);
      #2 i_resetn = 1;
      repeat (400) begin
        @(posedge i_clock);
        #2 drive();
      end
      i_resetn = 0;
    end
    final_report();
  end
  // Cut a hang short well past the planned run
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
endmodule
